/* speec_defs.vh */
`ifndef SPEEC_DEFS_VH
`define SPEEC_DEFS_VH
// ==========================================
// opcodes
`define SPEEC_OP_STATUS_READ  8'h05
`define SPEEC_OP_STATUS_WRITE 8'h01
`define SPEEC_OP_LATCH_SET    8'h06
`define SPEEC_OP_LATCH_CLEAR  8'h04
`define SPEEC_OP_PAGE_CLEAR   8'h42
`define SPEEC_OP_SECTOR_CLEAR 8'hd8
`define SPEEC_OP_CHIP_CLEAR   8'hc7
`define SPEEC_OP_SLEEP        8'hb9
`define SPEEC_OP_WAKE         8'hab
// ==========================================
// status fields
`define SPEEC_BIT_LOCK   7
`define SPEEC_BIT_BPH    3
`define SPEEC_BIT_BPL    2
`define SPEEC_BIT_LATCH  1
`define SPEEC_BIT_BUSY   0
`define SPEEC_NV_RESET   3'h0
// ==========================================
// timing, in ns, converted to clock cycles at 10 MHz
`define SPEEC_CLK_NS        100
`define SPEEC_WRITE_NS      2000
`define SPEEC_SETTLE_NS     3000
`define SPEEC_RELEASE_NS    3000
`define SPEEC_WRITE_CYC     ((`SPEEC_WRITE_NS + `SPEEC_CLK_NS - 1) / `SPEEC_CLK_NS)
`define SPEEC_SETTLE_CYC    ((`SPEEC_SETTLE_NS + `SPEEC_CLK_NS - 1) / `SPEEC_CLK_NS)
`define SPEEC_RELEASE_CYC   ((`SPEEC_RELEASE_NS + `SPEEC_CLK_NS - 1) / `SPEEC_CLK_NS)
// signature value is arbitrary, names no part
`define SPEEC_SIGNATURE     8'h5a
`endif

/* speec_sync.v */
`timescale 1ns/100ps
module speec_sync #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_reg;
    // ==========================================
    // two-stage synchroniser, first stage feeds only the second
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* speec_ctrl.v */
`timescale 1ns/100ps
`include "speec_defs.vh"
module speec_ctrl #(
    parameter WRITE_CYC   = `SPEEC_WRITE_CYC,
    parameter SETTLE_CYC  = `SPEEC_SETTLE_CYC,
    parameter RELEASE_CYC = `SPEEC_RELEASE_CYC
) (
    input  wire        MCLK,
    input  wire        RST,
    input  wire        CS_N,
    input  wire        SCK,
    input  wire        SI,
    input  wire        WP_N,
    output reg         SO,
    output reg         SO_OE,
    output wire [7:0]  STATUS_OUT,
    output reg         ERASE_PULSE,
    output reg  [1:0]  ERASE_KIND,
    output reg  [16:0] ERASE_ADDR,
    output reg         SLEEPING,
    output reg         LOW_POWER
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_BUSY  = 2'd1;
    localparam ST_SLEEP = 2'd2;
    localparam ST_WAKE  = 2'd3;
    localparam K_PAGE   = 2'd0;
    localparam K_SECTOR = 2'd1;
    localparam K_CHIP   = 2'd2;
    localparam K_STATUS = 2'd3;
    localparam [7:0] SIG_BYTE = `SPEEC_SIGNATURE;

    wire [3:0] pins_s;
    // select travels inverted so the synchroniser reset reads as deselected
    wire       cs_s  = ~pins_s[3];
    wire       sck_s = pins_s[2];
    wire       si_s  = pins_s[1];
    wire       wp_s  = pins_s[0];

    reg        cs_d_reg;
    reg        sck_d_reg;
    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    reg  [2:0] nv_reg;
    reg  [2:0] nv_pend_reg;
    reg        latch_reg;
    reg  [5:0] bitcnt_reg;
    reg  [7:0] op_reg;
    reg  [23:0] addr_reg;
    reg  [7:0] data_reg;
    reg  [7:0] shout_reg;
    reg  [15:0] timer_reg;
    reg  [15:0] timer_next;
    reg  [1:0] kind_reg;
    reg        active_reg;

    // ==========================================
    // pin synchronisation
    speec_sync #(.W(4)) u_sync (
        .clk (MCLK),
        .rst (RST),
        .d   ({~CS_N, SCK, SI, WP_N}),
        .q   (pins_s)
    );

    wire sck_rise = sck_s & ~sck_d_reg;
    wire sck_fall = ~sck_s & sck_d_reg;
    wire cs_fall  = ~cs_s & cs_d_reg;
    wire cs_rise  = cs_s & ~cs_d_reg;
    wire busy     = (state_reg == ST_BUSY);
    wire [7:0] status_w = {nv_reg[2], 3'h0, nv_reg[1:0], latch_reg, busy};

    assign STATUS_OUT = status_w;

    // ==========================================
    // protection decode
    function prot_hit;
        input [1:0]  bp;
        input [16:0] a;
        begin
            case (bp)
                2'b00:   prot_hit = 1'b0;
                2'b01:   prot_hit = (a[16:15] == 2'b11);
                2'b10:   prot_hit = a[16];
                default: prot_hit = 1'b1;
            endcase
        end
    endfunction

    wire op_done  = (bitcnt_reg == 6'd8);
    wire adr_done = (bitcnt_reg == 6'd32);
    wire bp_hit   = prot_hit(nv_reg[1:0], addr_reg[16:0]);
    // pin lock refuses status writes
    wire nv_lock  = nv_reg[2] & ~wp_s;

    // ==========================================
    // serial shift; ignored while deselected
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cs_d_reg   <= 1'b1;
            sck_d_reg  <= 1'b0;
            bitcnt_reg <= 6'h00;
            op_reg     <= 8'h00;
            addr_reg   <= 24'h000000;
            data_reg   <= 8'h00;
            active_reg <= 1'b0;
        end else begin
            cs_d_reg  <= cs_s;
            sck_d_reg <= sck_s;
            if (cs_fall) begin
                // a falling select edge is what wakes the interface
                bitcnt_reg <= 6'h00;
                active_reg <= 1'b1;
            end else if (cs_s) begin
                active_reg <= 1'b0;
            end else if (active_reg && sck_rise) begin
                if (bitcnt_reg != 6'h3f)
                    bitcnt_reg <= bitcnt_reg + 6'd1;
                if (bitcnt_reg < 6'd8)
                    op_reg <= {op_reg[6:0], si_s};
                else if (bitcnt_reg < 6'd32)
                    addr_reg <= {addr_reg[22:0], si_s};
                if (bitcnt_reg >= 6'd8 && bitcnt_reg < 6'd16)
                    data_reg <= {data_reg[6:0], si_s};
            end
        end
    end

    // ==========================================
    // status output shifter
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SO        <= 1'b0;
            SO_OE     <= 1'b0;
            shout_reg <= 8'h00;
        end else begin
            SO_OE <= active_reg & ~cs_s & (bitcnt_reg >= 6'd8)
                     & ((op_reg == `SPEEC_OP_STATUS_READ && state_reg != ST_SLEEP)
                        || (op_reg == `SPEEC_OP_WAKE && bitcnt_reg >= 6'd32));
            if (active_reg && sck_fall) begin
                if (op_reg == `SPEEC_OP_STATUS_READ && state_reg != ST_SLEEP
                    && bitcnt_reg[2:0] == 3'd0 && bitcnt_reg >= 6'd8) begin
                    // reload every eight bits until the bit counter saturates at 63, works mid-cycle
                    SO        <= status_w[7];
                    shout_reg <= {status_w[6:0], 1'b0};
                end else if (op_reg == `SPEEC_OP_WAKE && bitcnt_reg >= 6'd32
                             && bitcnt_reg[2:0] == 3'd0) begin
                    SO        <= SIG_BYTE[7];
                    shout_reg <= {SIG_BYTE[6:0], 1'b0};
                end else begin
                    SO        <= shout_reg[7];
                    shout_reg <= {shout_reg[6:0], 1'b0};
                end
            end
        end
    end

    // ==========================================
    // command execution on rising select, wake on its eighth bit
    always @* begin
        state_next = state_reg;
        timer_next = (timer_reg != 16'h0000) ? timer_reg - 16'd1 : 16'h0000;
        case (state_reg)
            ST_IDLE: begin
                if (cs_rise && active_reg && op_done
                    && op_reg == `SPEEC_OP_SLEEP) begin
                    state_next = ST_SLEEP;
                    timer_next = SETTLE_CYC[15:0];
                end
            end
            ST_BUSY: begin
                if (timer_reg == 16'h0001 || timer_reg == 16'h0000)
                    state_next = ST_IDLE;
            end
            ST_SLEEP: begin
                // only the wake opcode is honoured here
                if (active_reg && op_done && op_reg == `SPEEC_OP_WAKE) begin
                    state_next = ST_WAKE;
                    timer_next = RELEASE_CYC[15:0];
                end
            end
            ST_WAKE: begin
                if (timer_reg == 16'h0000 && cs_s)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg   <= ST_IDLE;
            timer_reg   <= 16'h0000;
            nv_reg      <= `SPEEC_NV_RESET;
            nv_pend_reg <= `SPEEC_NV_RESET;
            latch_reg   <= 1'b0;
            kind_reg    <= K_PAGE;
            ERASE_PULSE <= 1'b0;
            ERASE_KIND  <= K_PAGE;
            ERASE_ADDR  <= 17'h00000;
            SLEEPING    <= 1'b0;
            LOW_POWER   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            timer_reg   <= timer_next;
            ERASE_PULSE <= 1'b0;
            SLEEPING    <= (state_next == ST_SLEEP) || (state_next == ST_WAKE);
            LOW_POWER   <= (state_next == ST_SLEEP) && (timer_next == 16'h0000);
            if (state_reg == ST_IDLE && cs_rise && active_reg) begin
                // opcode only frames, deselect right after bit 8
                if (bitcnt_reg == 6'd8) begin
                    if (op_reg == `SPEEC_OP_LATCH_SET)
                        latch_reg <= 1'b1;
                    else if (op_reg == `SPEEC_OP_LATCH_CLEAR)
                        latch_reg <= 1'b0;
                    else if (op_reg == `SPEEC_OP_CHIP_CLEAR && latch_reg
                             && nv_reg[1:0] == 2'b00) begin
                        kind_reg  <= K_CHIP;
                        state_reg <= ST_BUSY;
                        timer_reg <= WRITE_CYC[15:0];
                    end
                end else if (bitcnt_reg == 6'd16 && op_reg == `SPEEC_OP_STATUS_WRITE
                             && latch_reg && !nv_lock) begin
                    nv_pend_reg <= {data_reg[7], data_reg[3:2]};
                    kind_reg    <= K_STATUS;
                    state_reg   <= ST_BUSY;
                    timer_reg   <= WRITE_CYC[15:0];
                end else if (adr_done && latch_reg && !bp_hit
                             && (op_reg == `SPEEC_OP_PAGE_CLEAR
                                 || op_reg == `SPEEC_OP_SECTOR_CLEAR)) begin
                    kind_reg  <= (op_reg == `SPEEC_OP_PAGE_CLEAR) ? K_PAGE : K_SECTOR;
                    state_reg <= ST_BUSY;
                    timer_reg <= WRITE_CYC[15:0];
                end
            end
            // other frames during busy are simply dropped
            if (state_reg == ST_BUSY && state_next == ST_IDLE) begin
                latch_reg   <= 1'b0;
                ERASE_PULSE <= (kind_reg != K_STATUS);
                ERASE_KIND  <= kind_reg;
                ERASE_ADDR  <= (kind_reg == K_SECTOR) ? {addr_reg[16:15], 15'h0000}
                             : (kind_reg == K_PAGE) ? {addr_reg[16:8], 8'h00} : 17'h00000;
                if (kind_reg == K_STATUS)
                    nv_reg <= nv_pend_reg;
            end
        end
    end
endmodule

/* speec_properties.sv */
`timescale 1ns/100ps
// ==========================================
// checker on the controller ports
module speec_props #(
    parameter int WRITE_CYC = 20
) (
    input wire        MCLK,
    input wire        RST,
    input wire        CS_N,
    input wire        SO_OE,
    input wire [7:0]  STATUS_OUT,
    input wire        ERASE_PULSE,
    input wire [1:0]  ERASE_KIND,
    input wire [16:0] ERASE_ADDR,
    input wire        SLEEPING,
    input wire        LOW_POWER
);
    localparam int W_HI = WRITE_CYC + 8;
    wire       busy = STATUS_OUT[0];
    wire [1:0] bp   = STATUS_OUT[3:2];
    wire       prot = bp == 2'h3 || (bp == 2'h2 && ERASE_ADDR[16])
                      || (bp == 2'h1 && ERASE_ADDR[16:15] == 2'h3);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // ==========================================
    // assertions
    a_busy_length: assert property ($rose(busy) |-> busy[*8] ##[0:W_HI] !busy)
        else $error("busy flag length wrong");
    a_pulse_busy: assert property (ERASE_PULSE |-> busy || $past(busy))
        else $error("erase strobe outside busy cycle");
    a_latch_drop: assert property ($fell(busy) |-> ##[0:2] !STATUS_OUT[1])
        else $error("latch kept after cycle");
    a_chip_free: assert property (ERASE_PULSE && ERASE_KIND == 2'h2 |-> bp == 2'h0)
        else $error("chip erase with protect bits set");
    a_no_protect: assert property (ERASE_PULSE && ERASE_KIND != 2'h2 |-> !prot)
        else $error("protected area erased");
    a_so_idle: assert property (CS_N [*6] |-> !SO_OE)
        else $error("serial out driven while deselected");
    a_sleep_hold: assert property (SLEEPING && $past(SLEEPING) |->
        $stable(STATUS_OUT) && !ERASE_PULSE)
        else $error("activity while sleeping");
    a_sleep_settle: assert property ($rose(SLEEPING) |->
        !LOW_POWER [*8] ##[1:40] LOW_POWER)
        else $error("settle delay wrong");
    // nonvolatile bits only move at the end of a write cycle
    a_nv_change: assert property ($changed({STATUS_OUT[7], bp}) |->
        $past(busy) || $past(busy, 2))
        else $error("protect bits changed outside write");
    cover property (ERASE_PULSE && ERASE_KIND == 2'h0);
    cover property (ERASE_PULSE && ERASE_KIND == 2'h1);
    cover property ($rose(SLEEPING));
endmodule

bind speec_ctrl speec_props #(.WRITE_CYC(WRITE_CYC)) props_u (
    .MCLK(MCLK), .RST(RST), .CS_N(CS_N), .SO_OE(SO_OE), .STATUS_OUT(STATUS_OUT),
    .ERASE_PULSE(ERASE_PULSE), .ERASE_KIND(ERASE_KIND), .ERASE_ADDR(ERASE_ADDR),
    .SLEEPING(SLEEPING), .LOW_POWER(LOW_POWER));

/* speec_host.sv */
`timescale 1ns/100ps
// ==========================================
// spi host, link clock still between frames
module speec_host (
    output reg        cs_n,
    output reg        sck,
    output reg        si,
    input  wire       so
);
    reg [15:0] rx;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b1;
    end
    task frame(input [31:0] d, input integer n, input integer rd);
        integer i;
        begin
            rx = 16'h0;
            cs_n = 1'b0;
            #400;
            for (i = 0; i < n + rd; i = i + 1) begin
                si = (i < n) ? d[n - 1 - i] : ~si;
                #400 sck = 1'b1;
                if (i >= n) rx = {rx[14:0], so};
                #400 sck = 1'b0;
            end
            #400 cs_n = 1'b1;
            si = ~si;
        end
    endtask
endmodule

/* speec_ctrl_tb.sv */
`timescale 1ns/100ps
`include "speec_defs.vh"
module speec_ctrl_tb;
    reg         MCLK, RST, WP_N;
    wire        CS_N, SCK, SI, SO, SO_OE, ERASE_PULSE, SLEEPING, LOW_POWER;
    wire [7:0]  STATUS_OUT;
    wire [1:0]  ERASE_KIND;
    wire [16:0] ERASE_ADDR;
    integer     errors, num_checks, pulses, k;
    reg  [1:0]  kind_seen;
    reg  [16:0] addr_seen;
    // released line shows a moving level, not the last bit
    wire        so_pin = SO_OE ? SO : ~SI;
    speec_host host_u (.cs_n(CS_N), .sck(SCK), .si(SI), .so(so_pin));
    speec_ctrl #(.WRITE_CYC(400)) dut_u (.MCLK(MCLK), .RST(RST), .CS_N(CS_N), .SCK(SCK),
        .SI(SI), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE), .STATUS_OUT(STATUS_OUT),
        .ERASE_PULSE(ERASE_PULSE), .ERASE_KIND(ERASE_KIND), .ERASE_ADDR(ERASE_ADDR),
        .SLEEPING(SLEEPING), .LOW_POWER(LOW_POWER));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // ==========================================
    // helpers
    task step(input integer n);
        begin
            repeat (n) @(posedge MCLK);
            #10;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input string what);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task idle;
        integer i, quiet;
        begin
            pulses = 0;
            quiet = -12;
            for (i = 0; i < 800 && quiet < 8; i = i + 1) begin
                step(1);
                if (ERASE_PULSE === 1'b1) begin
                    pulses = pulses + 1;
                    kind_seen = ERASE_KIND;
                    addr_seen = ERASE_ADDR;
                end
                quiet = (STATUS_OUT[0] === 1'b0) ? quiet + 1 : 0;
            end
            if (quiet < 8) begin
                errors = errors + 1;
                $display("wrong value busy expected 0 seen 1");
                test_done;
            end
        end
    endtask
    task cmd(input [31:0] d, input integer n, input integer latch);
        begin
            if (latch) host_u.frame(`SPEEC_OP_LATCH_SET, 8, 0);
            step(6);
            host_u.frame(d, n, 0);
            idle;
        end
    endtask
    // ==========================================
    // scenarios
    task t_latch;
        begin
            check(STATUS_OUT, 8'h00, "status");
            check(SO_OE, 1'b0, "so_oe");
            host_u.frame(`SPEEC_OP_LATCH_SET, 8, 0);
            step(8);
            check(STATUS_OUT[1], 1'b1, "latch");
            host_u.frame(`SPEEC_OP_LATCH_CLEAR, 8, 0);
            step(8);
            check(STATUS_OUT[1], 1'b0, "latch");
            cmd({`SPEEC_OP_SECTOR_CLEAR, 24'h0}, 32, 0);
            check(pulses, 0, "pulses");
            $display("test latch done");
        end
    endtask
    task t_status;
        begin
            host_u.frame(`SPEEC_OP_LATCH_SET, 8, 0);
            step(6);
            host_u.frame({`SPEEC_OP_STATUS_WRITE, 8'hff}, 16, 0);
            step(8);
            check(STATUS_OUT[0], 1'b1, "busy");
            host_u.frame(`SPEEC_OP_STATUS_READ, 8, 16);
            check(host_u.rx, 16'h0303, "status read");
            idle;
            check(STATUS_OUT, 8'h8c, "status");
            WP_N = 1'b0;
            cmd({`SPEEC_OP_STATUS_WRITE, 8'h00}, 16, 1);
            check(STATUS_OUT, 8'h8e, "status");
            WP_N = 1'b1;
            $display("test status done");
        end
    endtask
    task t_protect;
        begin
            for (k = 1; k < 4; k = k + 1) begin
                cmd({`SPEEC_OP_STATUS_WRITE, 4'h0, k[1:0], 2'h0}, 16, 1);
                check(STATUS_OUT, {4'h0, k[1:0], 2'h0}, "status");
                cmd({`SPEEC_OP_SECTOR_CLEAR, 24'h010000}, 32, 1);
                check(pulses, k == 1, "sector pulses");
                cmd({`SPEEC_OP_PAGE_CLEAR, 24'h008000}, 32, 1);
                check(pulses, k != 3, "page pulses");
                cmd(`SPEEC_OP_CHIP_CLEAR, 8, 1);
                check(pulses, 0, "chip pulses");
            end
            cmd({`SPEEC_OP_STATUS_WRITE, 8'h00}, 16, 1);
            check(STATUS_OUT, 8'h00, "status");
            $display("test protect done");
        end
    endtask
    task t_erase;
        begin
            cmd({`SPEEC_OP_PAGE_CLEAR, 24'h001234}, 32, 1);
            check({pulses[1:0], kind_seen, addr_seen}, {4'h4, 17'h01200}, "page");
            cmd({`SPEEC_OP_SECTOR_CLEAR, 24'h018123}, 32, 1);
            check({pulses[1:0], kind_seen, addr_seen}, {4'h5, 17'h18000}, "sector");
            cmd(`SPEEC_OP_CHIP_CLEAR, 8, 1);
            check({pulses[1:0], kind_seen}, 4'h6, "chip");
            check(STATUS_OUT, 8'h00, "status");
            cmd({`SPEEC_OP_SECTOR_CLEAR, 24'h018123} >> 1, 31, 1);
            check(pulses, 0, "short frame");
            $display("test erase done");
        end
    endtask
    task t_sleep;
        begin
            host_u.frame({`SPEEC_OP_SLEEP, 8'h00}, 16, 0);
            step(40);
            check(SLEEPING, 1'b0, "sleeping");
            host_u.frame(`SPEEC_OP_SLEEP, 8, 0);
            step(40);
            check({SLEEPING, LOW_POWER}, 2'h3, "sleep");
            host_u.frame(`SPEEC_OP_LATCH_CLEAR, 8, 0);
            step(8);
            check(STATUS_OUT, 8'h02, "status");
            host_u.frame({`SPEEC_OP_WAKE, 24'h0}, 32, 8);
            check(host_u.rx[7:0], `SPEEC_SIGNATURE, "signature");
            step(40);
            check(SLEEPING, 1'b0, "sleeping");
            $display("test sleep done");
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        RST = 1'b1;
        WP_N = 1'b1;
        repeat (6) @(posedge MCLK);
        #10 RST = 1'b0;
        step(4);
        t_latch;
        t_status;
        t_protect;
        t_erase;
        t_sleep;
        test_done;
    end
endmodule
